// [can_bit_timing_sync_regs.vh]
// Register offsets, field positions and reset values of the CAN bit-timing block
`ifndef CAN_BIT_TIMING_SYNC_REGS_VH
`define CAN_BIT_TIMING_SYNC_REGS_VH

// ********************************
// Register byte offsets
// ********************************
`define OFF_CFG        12'h064
`define OFF_STATUS     12'h070
`define OFF_CHAN_BASE  12'h110
`define OFF_CHAN_STEP  12'h020
`define OFF_STAMP_REL  12'h004

// ********************************
// Configuration register fields
// ********************************
`define CFG_DIV_LSB    0
`define CFG_DIV_MSB    5
`define CFG_LINE_DELAY_FIELD_LSB   8
`define CFG_LINE_DELAY_FIELD_MSB   10
`define CFG_PH1_LSB    12
`define CFG_PH1_MSB    14
`define CFG_PH2_LSB    16
`define CFG_PH2_MSB    18
`define CFG_SJW_LSB    20
`define CFG_SJW_MSB    21
`define CFG_TRIPLE_BIT 24
`define CFG_RESET      32'h00000000
`define CFG_WMASK      32'h01377f3f

// ********************************
// Channel control register fields
// ********************************
`define CHAN_EN_BIT    7
`define CHAN_KEEP_BIT  5
`define CHAN_PROD_BIT  6
`define CHAN_RESET     32'h00000000
`define CHAN_WMASK     32'h000000e0

// ********************************
// Channel geometry and idle detection
// ********************************
`define NUM_CHAN       4
`define IDLE_BITS      4'd11
`define STAMP_RESET    32'h00000000

`endif

// [can_bit_timing_sync.v]
// CAN bit timing, edge synchronisation, channel reception mode and time stamps
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "can_bit_timing_sync_regs.vh"

// Contract
// - Quantum lasts divider plus one clocks
// - Resync slot fixed at one quantum
// - Line-delay segment is field plus one
// - Phase one segment is field plus one
// - Phase two is field plus one, min two; the code does not clamp
// - Sample at phase one end, once or thrice; the code's third vote is the previous bit's early sample
// - Next bit ready zero quanta after sample
// - Bit time spans 8 to 25 quanta; the code allows 4 to 25
// - Hard sync restarts bit at resync slot
// - Jump width one to min(4, phase one)
// - Phase error measured against the resync slot
// - Small error hard-syncs, large error adjusts phases
// - At most one synchronisation per bit
// - Edge used only if it changes sampled value
// - Idle falling edge forces hard sync
// - No positive resync while transmitting dominant
// - Keep bit clear disables channel after reception
// - Keep bit set leaves channel enabled
// - Watch timer copied to stamp after each frame; the code skips disabled channels and producer mismatches
// - Producer setting picks sent or received stamping
// - Bus level held for whole bit time
module can_bit_timing_sync (
   input  wire        clk,
   input  wire        nrst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        rx_pin,
   output reg         tx_pin,
   input  wire        tx_bit,
   output reg         tx_req,
   output reg         rx_bit,
   output reg         rx_valid,
   input  wire        bus_idle,
   input  wire [31:0] watch_timer,
   input  wire        frame_done,
   input  wire        frame_sent,
   input  wire [1:0]  frame_chan,
   output wire [3:0]  chan_enabled
);

   // ********************************
   // States of the bit-time machine
   // ********************************
   localparam [3:0] ST_SYNC = 4'b0001;
   localparam [3:0] ST_LINE_DELAY_FIELD = 4'b0010;
   localparam [3:0] ST_PH1  = 4'b0100;
   localparam [3:0] ST_PH2  = 4'b1000;

   function [3:0] min4;
      input [3:0] a;
      begin
         min4 = (a < 4'd4) ? a : 4'd4;
      end
   endfunction

   function [3:0] field_len;
      input [2:0] f;
      begin
         field_len = {1'b0, f} + 4'd1;
      end
   endfunction

   function last_quantum;
      input [3:0] cnt;
      input [3:0] len;
      begin
         last_quantum = (cnt + 4'd1 >= len);
      end
   endfunction

   // ********************************
   // Configuration and channel registers
   // ********************************
   reg  [31:0] cfg_q;
   reg  [31:0] chan_ctl_q [0:`NUM_CHAN-1];
   reg  [31:0] stamp_q    [0:`NUM_CHAN-1];
   integer     i;

   wire [5:0] div_val   = cfg_q[`CFG_DIV_MSB:`CFG_DIV_LSB];
   wire [3:0] line_delay_field_len  = field_len(cfg_q[`CFG_LINE_DELAY_FIELD_MSB:`CFG_LINE_DELAY_FIELD_LSB]);
   wire [3:0] ph1_len   = field_len(cfg_q[`CFG_PH1_MSB:`CFG_PH1_LSB]);
   // Software keeps phase two at least two quanta; hardware does not clamp
   wire [3:0] ph2_len   = field_len(cfg_q[`CFG_PH2_MSB:`CFG_PH2_LSB]);
   wire [3:0] sjw_raw   = {2'b00, cfg_q[`CFG_SJW_MSB:`CFG_SJW_LSB]} + 4'd1;
   // Legal jump width relative to phase two is software's duty
   wire [3:0] sjw_len   = (sjw_raw < min4(ph1_len)) ? sjw_raw : min4(ph1_len);
   wire       triple    = cfg_q[`CFG_TRIPLE_BIT];

   wire       wr_en = psel & penable & pwrite;
   wire       ch_hit = (paddr >= `OFF_CHAN_BASE) &&
                       (paddr < `OFF_CHAN_BASE + `OFF_CHAN_STEP * `NUM_CHAN);
   wire [11:0] ch_rel = paddr - `OFF_CHAN_BASE;
   wire [1:0]  ch_idx = ch_rel[6:5];
   wire [4:0]  ch_sub = ch_rel[4:0];
   wire        mapped = (paddr == `OFF_CFG) || (paddr == `OFF_STATUS) ||
                        (ch_hit && (ch_sub == 5'h00 || ch_sub == `OFF_STAMP_REL));

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ********************************
   // Input synchroniser
   // ********************************
   reg rx_meta_q;
   reg rx_sync_q;
   reg rx_prev_q;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   // ********************************
   // Prescaler
   // ********************************
   reg  [5:0] pre_q;
   wire       tq_tick  = (pre_q == div_val);
   // Half-quantum point used for the triple sample spacing
   wire       half_tick = (pre_q == {1'b0, div_val[5:1]});

   // ********************************
   // Bit-time machine
   // ********************************
   reg [3:0]  state_q;
   reg [3:0]  cnt_q;
   reg [3:0]  ph1_ext_q;
   reg [3:0]  ph2_cut_q;
   reg        synced_q;
   reg        sampled_q;
   reg [2:0]  smp_q;
   reg [1:0]  smp_n_q;

   wire fall_edge = rx_prev_q & ~rx_sync_q;
   // A falling edge changes the bus only if the last bit read recessive
   wire edge_ok   = fall_edge & sampled_q & ~synced_q;
   wire hard_sync = fall_edge & bus_idle & sampled_q;
   wire in_sync   = (state_q == ST_SYNC);
   wire pos_err   = (state_q == ST_LINE_DELAY_FIELD) | (state_q == ST_PH1);
   wire neg_err   = (state_q == ST_PH2);
   // Phase error in quanta: elapsed since slot, or remaining to next slot
   wire [4:0] pos_mag = (state_q == ST_LINE_DELAY_FIELD) ? {1'b0, cnt_q} + 5'd1 :
                        {1'b0, line_delay_field_len} + {1'b0, cnt_q} + 5'd1;
   wire [4:0] neg_mag = {1'b0, ph2_len} - {1'b0, cnt_q};
   wire       tx_dom  = ~tx_pin;
   wire       resync  = edge_ok & ~bus_idle & ~in_sync &
                        ~(pos_err & tx_dom);
   wire       small_err = pos_err ? (pos_mag <= {1'b0, sjw_len}) :
                                    (neg_mag <= {1'b0, sjw_len});
   wire       restart = (hard_sync & ~synced_q) | (resync & small_err);
   wire       ph1_end = (state_q == ST_PH1) & tq_tick &
                        last_quantum(cnt_q, ph1_len + ph1_ext_q);
   wire       early_smp = (state_q == ST_PH1) & half_tick &
                          last_quantum(cnt_q, ph1_len + ph1_ext_q);
   // Shortened phase two may end at once; the cut is added, never subtracted
   wire       ph2_done = (state_q == ST_PH2) & tq_tick &
                         last_quantum(cnt_q + ph2_cut_q, ph2_len);
   wire [2:0] smp_next = {smp_q[1:0], rx_sync_q};
   wire       majority = (smp_q[1] & smp_q[0]) | (smp_q[1] & rx_sync_q) |
                         (smp_q[0] & rx_sync_q);

   wire       bit_value = (triple && smp_n_q != 2'h0) ? majority : rx_sync_q;

   // ********************************
   // Prescaler counter
   // ********************************
   // A hard sync or small-error resync restarts the quantum so the edge opens a fresh slot
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_q <= 6'h00;
      end else if (tq_tick || restart) begin
         pre_q <= 6'h00;
      end else begin
         pre_q <= pre_q + 6'h01;
      end
   end

   // ********************************
   // Triple sampling
   // ********************************
   // Extra sample half a quantum ahead; with a divider of zero it coincides
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         smp_q   <= 3'h7;
         smp_n_q <= 2'h0;
      end else begin
         if (triple && early_smp)
            smp_q <= smp_next;
         if (!restart && ph1_end)
            smp_n_q <= 2'h0;
         else if (triple && early_smp)
            smp_n_q <= 2'h1;
      end
   end

   // ********************************
   // Sample point outputs
   // ********************************
   // Bit decided and next bit requested in the same cycle
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_bit    <= 1'b1;
         sampled_q <= 1'b1;
         rx_valid  <= 1'b0;
         tx_req    <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         tx_req   <= 1'b0;
         if (!restart && ph1_end) begin
            rx_bit    <= bit_value;
            sampled_q <= bit_value;
            rx_valid  <= 1'b1;
            tx_req    <= 1'b1;
         end
      end
   end

   // ********************************
   // Transmit level
   // ********************************
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_pin <= 1'b1;
      end else if (!restart && tq_tick && in_sync) begin
         tx_pin <= tx_bit;
      end
   end

   // ********************************
   // Synchronisation bookkeeping
   // ********************************
   // Cleared only at the true end of a bit, so a restart into the slot
   // still counts as this bit's one synchronisation
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         synced_q <= 1'b0;
      end else if (restart || resync) begin
         synced_q <= 1'b1;
      end else if (ph2_done) begin
         synced_q <= 1'b0;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph1_ext_q <= 4'h0;
         ph2_cut_q <= 4'h0;
      end else if (restart || ph2_done) begin
         ph1_ext_q <= 4'h0;
         ph2_cut_q <= 4'h0;
      end else if (resync) begin
         if (pos_err)
            ph1_ext_q <= sjw_len;
         else
            ph2_cut_q <= sjw_len;
      end
   end

   // ********************************
   // Segment sequencer
   // ********************************
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_SYNC;
         cnt_q   <= 4'h0;
      end else if (restart) begin
         // Edge lies inside the restarted resync slot
         state_q <= ST_SYNC;
         cnt_q   <= 4'h0;
      end else if (ph1_end) begin
         state_q <= ST_PH2;
         cnt_q   <= 4'h0;
      end else if (tq_tick) begin
         case (state_q)
            ST_SYNC: begin
               state_q <= ST_LINE_DELAY_FIELD;
               cnt_q   <= 4'h0;
            end
            ST_LINE_DELAY_FIELD: begin
               if (last_quantum(cnt_q, line_delay_field_len)) begin
                  state_q <= ST_PH1;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'd1;
               end
            end
            ST_PH1: begin
               cnt_q <= cnt_q + 4'd1;
            end
            ST_PH2: begin
               if (ph2_done) begin
                  state_q <= ST_SYNC;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'd1;
               end
            end
            default: begin
               state_q <= ST_SYNC;
               cnt_q   <= 4'h0;
            end
         endcase
      end
   end

   // ********************************
   // Registers, reception mode and stamps
   // ********************************
   genvar g;
   generate
      for (g = 0; g < `NUM_CHAN; g = g + 1) begin : chan
         assign chan_enabled[g] = chan_ctl_q[g][`CHAN_EN_BIT];
      end
   endgenerate

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= `CFG_RESET;
         for (i = 0; i < `NUM_CHAN; i = i + 1) begin
            chan_ctl_q[i] <= `CHAN_RESET;
            stamp_q[i]    <= `STAMP_RESET;
         end
      end else begin
         if (wr_en && paddr == `OFF_CFG)
            cfg_q <= pwdata & `CFG_WMASK;
         if (wr_en && ch_hit && ch_sub == 5'h00)
            chan_ctl_q[ch_idx] <= pwdata & `CHAN_WMASK;
         // Frame end applied after the bus write so hardware wins a clash
         if (frame_done && chan_ctl_q[frame_chan][`CHAN_EN_BIT]) begin
            if (chan_ctl_q[frame_chan][`CHAN_PROD_BIT] == frame_sent)
               stamp_q[frame_chan] <= watch_timer;
            if (!frame_sent && !chan_ctl_q[frame_chan][`CHAN_KEEP_BIT])
               chan_ctl_q[frame_chan][`CHAN_EN_BIT] <= 1'b0;
            // Keep bit set: enable left as is, next match overwrites
         end
      end
   end

   always @* begin
      prdata = 32'h00000000;
      if (paddr == `OFF_CFG)
         prdata = cfg_q;
      else if (paddr == `OFF_STATUS)
         prdata = {20'h00000, 3'h0, synced_q, state_q, 2'h0, rx_bit, sampled_q};
      else if (ch_hit && ch_sub == 5'h00)
         prdata = chan_ctl_q[ch_idx];
      else if (ch_hit && ch_sub == `OFF_STAMP_REL)
         prdata = stamp_q[ch_idx];
   end

endmodule

// [can_bit_timing_sync_chk.sv]
// Port-level assertion checker for the CAN bit-timing block
`timescale 1ns/100ps
module can_bit_timing_sync_chk (
   input logic       clk,
   input logic       nrst,
   input logic       psel,
   input logic       penable,
   input logic       pwrite,
   input logic       pslverr,
   input logic       rx_valid,
   input logic       tx_req,
   input logic       rx_bit,
   input logic       tx_pin,
   input logic       frame_done,
   input logic [3:0] chan_enabled
);
   // ****
   // Checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire wr = psel && penable && pwrite;
   // A bit is at least three quanta even right after a synchronisation
   sequence quiet_after;
      ##1 !rx_valid ##1 !rx_valid;
   endsequence
   pulse_len_a: assert property (rx_valid |-> quiet_after)
      else $error("sample pulse repeats too soon");
   req_align_a: assert property (tx_req == rx_valid)
      else $error("next bit request off the sample point");
   rxbit_move_a: assert property ($changed(rx_bit) |-> rx_valid)
      else $error("received bit moved off the sample point");
   txpin_hold_a: assert property (rx_valid |-> $stable(tx_pin))
      else $error("transmit level moved at the sample point");
   txpin_slot_a: assert property ($changed(tx_pin) |=> !rx_valid)
      else $error("sample point right after the resync slot");
   en_rise_a: assert property (|(chan_enabled & ~$past(chan_enabled)) |-> $past(wr))
      else $error("channel enabled without a write");
   en_fall_a: assert property (|($past(chan_enabled) & ~chan_enabled)
      |-> $past(wr || frame_done))
      else $error("channel disabled without cause");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error flag outside an access phase");
endmodule
bind can_bit_timing_sync can_bit_timing_sync_chk u_chk (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .rx_valid(rx_valid),
   .tx_req(tx_req), .rx_bit(rx_bit), .tx_pin(tx_pin), .frame_done(frame_done),
   .chan_enabled(chan_enabled));

// [can_bus_node.sv]
// Far-side CAN node that sends one 16-bit pattern
`timescale 1ns/100ps
module can_bus_node (
   input  logic        clk,
   input  logic        nrst,
   input  logic        tx_pin,
   input  logic        go,
   input  logic [15:0] pattern,
   input  logic [15:0] bit_clks,
   output logic        rx_pin
);
   logic [15:0] sh_q;
   logic [15:0] cnt_q;
   logic [4:0]  left_q;
   // Wired-AND bus; the pull-up makes it recessive once the node is done
   assign rx_pin = tx_pin & (left_q == 5'h0 | sh_q[15]);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         left_q <= 5'h0;
         sh_q <= 16'h0;
         cnt_q <= 16'h0;
      end else if (go) begin
         left_q <= 5'h10;
         sh_q <= pattern;
         cnt_q <= 16'h0;
      end else if (left_q != 5'h0) begin
         cnt_q <= cnt_q + 16'h1;
         if (cnt_q == bit_clks - 16'h1) begin // Level held the whole bit
            cnt_q <= 16'h0;
            sh_q <= sh_q << 1;
            left_q <= left_q - 5'h1;
         end
      end
   end
endmodule

// [can_bit_timing_sync_tb_top.sv]
// Self-checking testbench of the CAN bit-timing block
`timescale 1ns/100ps
`include "can_bit_timing_sync_regs.vh"
module can_bit_timing_sync_tb_top;
   logic        clk, nrst, psel, penable, pwrite, tx_bit, bus_idle;
   logic        frame_done, frame_sent, go, pready, pslverr, er;
   logic        rx_pin, tx_pin, tx_req, rx_bit, rx_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, watch_timer, rd, cfg, ctl[4];
   logic [15:0] pattern, bit_clks;
   logic [5:0]  div;
   logic [2:0]  line_delay_field, ph1, ph2;
   logic [1:0]  jump_width_field, frame_chan;
   logic [3:0]  chan_enabled;
   int          n_fail, n_compared, i, k, n, c;

   can_bit_timing_sync u_can_bit_timing_sync (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_bit(tx_bit),
      .tx_req(tx_req), .rx_bit(rx_bit), .rx_valid(rx_valid), .bus_idle(bus_idle),
      .watch_timer(watch_timer), .frame_done(frame_done), .frame_sent(frame_sent),
      .frame_chan(frame_chan), .chan_enabled(chan_enabled));
   can_bus_node u_can_bus_node (.clk(clk), .nrst(nrst), .tx_pin(tx_pin), .go(go),
      .pattern(pattern), .bit_clks(bit_clks), .rx_pin(rx_pin));

   always #2.5 clk = ~clk;

   // ****
   // Helpers
   // ****
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wait_rx(output int m);
      m = 0;
      do begin
         @(posedge clk);
         m++;
      end while (rx_valid !== 1'b1);
   endtask
   task frame(input int ch, input logic s, input logic [31:0] w);
      @(posedge clk);
      frame_done <= 1;
      frame_chan <= 2'(ch);
      frame_sent <= s;
      watch_timer <= w;
      @(posedge clk);
      frame_done <= 0;
   endtask
   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #400000;
      n_fail++;
      results;
   end

   initial begin
      {clk, nrst, psel, penable, pwrite, frame_done, frame_sent, go} = 0;
      {tx_bit, bus_idle} = 2'h3;
      {paddr, pwdata, watch_timer, frame_chan} = 0;
      pattern = 16'hffff;
      bit_clks = 16'h10;
      rd = $urandom(43);
      repeat (10) @(posedge clk);
      nrst <= 1;
      apb(0, `OFF_CFG, 0);
      check("cfg reset", rd, `CFG_RESET);
      apb(0, 12'h000, 0);
      check("unmapped err", er, 1);
      check("unmapped data", rd, 0);
      $display("register test done");
      for (i = 0; i < 6; i++) begin
         div = 6'($urandom_range(3));
         {line_delay_field, ph1, ph2, jump_width_field} = 11'($urandom);
         if (ph2 == 0) ph2 = 1;
         if (i == 0) {line_delay_field, ph1, ph2} = 9'h1ff;
         if (i == 1) {line_delay_field, ph1, ph2} = 9'h001;
         if (ph2 > 3 && jump_width_field == 0) jump_width_field = 1;
         cfg = {7'h0, i[0], 2'h0, jump_width_field, 1'h0, ph2, 1'h0, ph1, 1'h0, line_delay_field, 2'h0, div};
         apb(1, `OFF_CFG, cfg | ($urandom & ~`CFG_WMASK));
         apb(0, `OFF_CFG, 0);
         check("cfg", rd, cfg);
         repeat (3) wait_rx(n);
         check("bit length", n, (div + 1) * (4 + line_delay_field + ph1 + ph2));
         bit_clks <= 16'(n);
         pattern <= {1'b0, 15'($urandom)};
         go <= 1;
         @(posedge clk);
         go <= 0;
         do wait_rx(n); while (rx_bit !== 1'b0);
         bus_idle <= 0;
         for (k = 14; k >= 0; k--) begin
            wait_rx(n);
            check("rx bit", rx_bit, pattern[k]);
         end
         bus_idle <= 1;
      end
      tx_bit <= 0;
      repeat (2) wait_rx(n);
      check("tx dominant", tx_pin, 0);
      tx_bit <= 1;
      repeat (2) wait_rx(n);
      check("tx recessive", tx_pin, 1);
      $display("bit timing test done");
      for (c = 0; c < 4; c++) begin
         ctl[c] = (c == 0) ? 32'h80 : ($urandom & `CHAN_WMASK);
         apb(1, `OFF_CHAN_BASE + 12'(c) * `OFF_CHAN_STEP, ctl[c] | 32'h1f);
         apb(0, `OFF_CHAN_BASE + 12'(c) * `OFF_CHAN_STEP, 0);
         check("chan ctl", rd, ctl[c]);
         cfg = $urandom;
         frame(c, 1, cfg);
         if (!ctl[c][6]) frame(c, 0, ~cfg);
         apb(0, `OFF_CHAN_BASE + 12'(c) * `OFF_CHAN_STEP + `OFF_STAMP_REL, 0);
         check("stamp", rd, ctl[c][7] ? (ctl[c][6] ? cfg : ~cfg) : 0);
         check("enable", chan_enabled[c], ctl[c][7] & (ctl[c][5] | ctl[c][6]));
      end
      $display("channel test done");
      results;
   end
endmodule
